// ### lrcc_pkg.sv
// Package with register map, field positions, mode codes and serial frame constants of the clock configuration block.
package lrcc_pkg;
	localparam int LRCC_DATA_W = 5;
	localparam int LRCC_ADDR_W = 3;
	localparam int LRCC_NUM_REGS = 5;
	localparam logic [LRCC_ADDR_W-1:0] LRCC_MODE_FIRST_OFS = 3'h0;
	localparam logic [LRCC_ADDR_W-1:0] LRCC_MULT_SECOND_OFS = 3'h1;
	localparam logic [LRCC_ADDR_W-1:0] LRCC_FIRST_DIV_OFS = 3'h2;
	localparam logic [LRCC_ADDR_W-1:0] LRCC_SECOND_DIV_OFS = 3'h3;
	localparam logic [LRCC_ADDR_W-1:0] LRCC_OUT_EN_OFS = 3'h4;
	localparam logic [LRCC_DATA_W-1:0] LRCC_REG_RESET = 5'h00;
	// Field positions inside a command register.
	localparam int LRCC_LOOP_EN_BIT = 0;
	localparam int LRCC_CODE_LSB = 1;
	localparam int LRCC_CODE_W = 4;
	localparam int LRCC_FRAME_EN_BIT = 4;
	localparam int LRCC_DRV1_EN_BIT = 3;
	localparam int LRCC_DRV2_EN_BIT = 2;
	localparam int LRCC_LOCK2_BIT = 1;
	localparam int LRCC_LOCK1_BIT = 0;
	// Mode code that selects forward master or reverse slave depending on the pin.
	localparam logic [LRCC_CODE_W-1:0] LRCC_CODE_LINE_RATE = 4'h8;
	localparam logic [LRCC_DATA_W-1:0] LRCC_DIV_REQUIRED = 5'h1F;
	// Serial frame: one read flag, three address bits, five data bits, all LSB first.
	localparam logic [3:0] LRCC_ADDR_START = 4'h1;
	localparam logic [3:0] LRCC_DATA_START = 4'h4;
	localparam logic [3:0] LRCC_FRAME_BITS = 4'h9;
endpackage : lrcc_pkg

// ### lrcc_reg_if.sv
// Interface between the serial port engine and the command register file.
`timescale 1ns/1ps
interface lrcc_reg_if;
	import lrcc_pkg::*;
	logic wr_stb;
	logic [LRCC_ADDR_W-1:0] addr;
	logic [LRCC_DATA_W-1:0] wdata;
	logic [LRCC_DATA_W-1:0] rdata;
	modport port (output wr_stb, output addr, output wdata, input rdata);
	modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : lrcc_reg_if

// ### lrcc_serial_port.sv
// Serial port engine that turns framed bits into register writes and shifts register contents back out.
`timescale 1ns/1ps
module lrcc_serial_port
	import lrcc_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic reset_n_i,
	// Serial pins.
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic cs_n_i,
	output logic sdo_o,
	// Register side.
	lrcc_reg_if.port bus
);
	typedef struct packed {
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_s3;
		logic sdi_s1;
		logic sdi_s2;
		logic cs_s1;
		logic cs_s2;
		logic [3:0] cnt;
		logic rd;
		logic [LRCC_ADDR_W-1:0] addr;
		logic [LRCC_DATA_W-1:0] data;
		logic sdo;
		logic wr_stb;
	} lrcc_sp_s;

	lrcc_sp_s state_reg;
	lrcc_sp_s state_next;

	always_comb begin
		state_next = state_reg;
		state_next.wr_stb = 1'b0;
		state_next.sclk_s1 = sclk_i;
		state_next.sclk_s2 = state_reg.sclk_s1;
		state_next.sclk_s3 = state_reg.sclk_s2;
		state_next.sdi_s1 = sdi_i;
		state_next.sdi_s2 = state_reg.sdi_s1;
		state_next.cs_s1 = cs_n_i;
		state_next.cs_s2 = state_reg.cs_s1;
		if (state_reg.cs_s2) begin
			// A write only lands once the whole frame is in and select is released.
			if (state_reg.cnt == LRCC_FRAME_BITS && !state_reg.rd) begin
				state_next.wr_stb = 1'b1;
			end
			state_next.cnt = 4'h0;
			state_next.sdo = 1'b0;
		end else if (state_reg.sclk_s2 && !state_reg.sclk_s3 && state_reg.cnt < LRCC_FRAME_BITS) begin
			if (state_reg.cnt < LRCC_ADDR_START) begin
				state_next.rd = state_reg.sdi_s2;
			end else if (state_reg.cnt < LRCC_DATA_START) begin
				state_next.addr = {state_reg.sdi_s2, state_reg.addr[LRCC_ADDR_W-1:1]};
			end else begin
				state_next.data = {state_reg.sdi_s2, state_reg.data[LRCC_DATA_W-1:1]};
			end
			state_next.cnt = state_reg.cnt + 4'h1;
		end else if (!state_reg.sclk_s2 && state_reg.sclk_s3 && state_reg.rd
			&& state_reg.cnt >= LRCC_DATA_START && state_reg.cnt < LRCC_FRAME_BITS) begin
			state_next.sdo = bus.rdata[3'(state_reg.cnt - LRCC_DATA_START)];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_reg <= '{sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0, sdi_s1: 1'b0, sdi_s2: 1'b0,
				cs_s1: 1'b1, cs_s2: 1'b1, cnt: 4'h0, rd: 1'b0, addr: 3'h0, data: 5'h00,
				sdo: 1'b0, wr_stb: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus.wr_stb = state_reg.wr_stb;
	assign bus.addr = state_reg.addr;
	assign bus.wdata = state_reg.data;
	assign sdo_o = state_reg.sdo;
endmodule : lrcc_serial_port

// ### lrcc_line_rate_clock_config.sv
// Command register file and mode decode of the line rate clock synthesizer configuration block.
`timescale 1ns/1ps
// Operation
// - Pin high, code 1000: forward master mode.
// - Pin low, code 1000: reverse slave mode.
// - No direct 1.544 to 1.544 mode exists.
// - First register bit 0 enables first loop.
// - Second register bit 0 enables second loop.
// - Forward mode multiple is second code plus one.
// - Output register gates frame, drivers, lock detect.
module lrcc_line_rate_clock_config
	import lrcc_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic reset_n_i,
	// Serial port pins.
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic cs_n_i,
	output logic sdo_o,
	// Master/slave pin, driven by the line rate select.
	input wire logic line_rate_select_i,
	// Lock status from the analog loops.
	input wire logic first_loop_locked_i,
	input wire logic second_loop_locked_i,
	// Configuration outputs to the synthesizer core.
	output logic forward_master_o,
	output logic reverse_slave_o,
	output logic [LRCC_DATA_W-1:0] reference_multiple_o,
	output logic first_loop_enable_o,
	output logic second_loop_enable_o,
	output logic first_output_driver_o,
	output logic second_output_driver_o,
	output logic frame_pulse_output_o,
	output logic pll_lock_indicator_o,
	output logic config_fault_o
);
	typedef struct packed {
		logic [LRCC_NUM_REGS-1:0][LRCC_DATA_W-1:0] cmd;
		logic ms_s1;
		logic ms_s2;
		logic lk1_s1;
		logic lk1_s2;
		logic lk2_s1;
		logic lk2_s2;
		logic fwd;
		logic rev;
		logic [LRCC_DATA_W-1:0] mult;
		logic loop1;
		logic loop2;
		logic drv1;
		logic drv2;
		logic frame;
		logic lock;
		logic fault;
	} lrcc_top_s;

	lrcc_top_s state_reg;
	lrcc_top_s state_next;
	lrcc_reg_if reg_bus ();

	lrcc_serial_port u_serial (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.sclk_i(sclk_i),
		.sdi_i(sdi_i),
		.cs_n_i(cs_n_i),
		.sdo_o(sdo_o),
		.bus(reg_bus)
	);

	function automatic logic [LRCC_CODE_W-1:0] code_of(input logic [LRCC_DATA_W-1:0] value);
		code_of = value[LRCC_CODE_LSB +: LRCC_CODE_W];
	endfunction : code_of

	// Unmapped addresses read as zero.
	assign reg_bus.rdata = (reg_bus.addr < LRCC_ADDR_W'(LRCC_NUM_REGS)) ? state_reg.cmd[reg_bus.addr] : 5'h00;

	always_comb begin
		logic line_code;
		logic out1;
		logic out2;
		line_code = 1'b0;
		out1 = 1'b0;
		out2 = 1'b0;
		state_next = state_reg;
		state_next.ms_s1 = line_rate_select_i;
		state_next.ms_s2 = state_reg.ms_s1;
		state_next.lk1_s1 = first_loop_locked_i;
		state_next.lk1_s2 = state_reg.lk1_s1;
		state_next.lk2_s1 = second_loop_locked_i;
		state_next.lk2_s2 = state_reg.lk2_s1;
		if (reg_bus.wr_stb && reg_bus.addr < LRCC_ADDR_W'(LRCC_NUM_REGS)) begin
			state_next.cmd[reg_bus.addr] = reg_bus.wdata;
		end
		line_code = code_of(state_reg.cmd[LRCC_MODE_FIRST_OFS]) == LRCC_CODE_LINE_RATE;
		state_next.fwd = line_code && state_reg.ms_s2;
		state_next.rev = line_code && !state_reg.ms_s2;
		// Forward mode takes Q from the second register; reverse slave always uses one.
		state_next.mult = state_reg.ms_s2
			? {1'b0, code_of(state_reg.cmd[LRCC_MULT_SECOND_OFS])} + 5'h01 : 5'h01;
		state_next.loop1 = state_reg.cmd[LRCC_MODE_FIRST_OFS][LRCC_LOOP_EN_BIT];
		state_next.loop2 = state_reg.cmd[LRCC_MULT_SECOND_OFS][LRCC_LOOP_EN_BIT];
		out1 = state_reg.cmd[LRCC_OUT_EN_OFS][LRCC_DRV1_EN_BIT];
		out2 = state_reg.cmd[LRCC_OUT_EN_OFS][LRCC_DRV2_EN_BIT];
		state_next.drv1 = state_next.loop1 && out1 && line_code;
		state_next.drv2 = state_next.loop2 && out2 && line_code;
		state_next.frame = state_reg.cmd[LRCC_OUT_EN_OFS][LRCC_FRAME_EN_BIT] && line_code;
		// Lock shows only when every loop that is both running and watched is locked.
		state_next.lock = line_code
			&& ((state_next.loop1 && state_reg.cmd[LRCC_OUT_EN_OFS][LRCC_LOCK1_BIT])
			|| (state_next.loop2 && state_reg.cmd[LRCC_OUT_EN_OFS][LRCC_LOCK2_BIT]))
			&& (!(state_next.loop1 && state_reg.cmd[LRCC_OUT_EN_OFS][LRCC_LOCK1_BIT]) || state_reg.lk1_s2)
			&& (!(state_next.loop2 && state_reg.cmd[LRCC_OUT_EN_OFS][LRCC_LOCK2_BIT]) || state_reg.lk2_s2);
		// Any other code is outside the line rate conversion and is flagged rather than guessed at.
		state_next.fault = !line_code
			|| (state_reg.ms_s2 && (state_reg.cmd[LRCC_FIRST_DIV_OFS] != LRCC_DIV_REQUIRED
			|| state_reg.cmd[LRCC_SECOND_DIV_OFS] != LRCC_DIV_REQUIRED));
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_reg <= '{cmd: {LRCC_NUM_REGS{LRCC_REG_RESET}}, ms_s1: 1'b0, ms_s2: 1'b0, lk1_s1: 1'b0,
				lk1_s2: 1'b0, lk2_s1: 1'b0, lk2_s2: 1'b0, fwd: 1'b0, rev: 1'b0, mult: 5'h01,
				loop1: 1'b0, loop2: 1'b0, drv1: 1'b0, drv2: 1'b0, frame: 1'b0, lock: 1'b0, fault: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign forward_master_o = state_reg.fwd;
	assign reverse_slave_o = state_reg.rev;
	assign reference_multiple_o = state_reg.mult;
	assign first_loop_enable_o = state_reg.loop1;
	assign second_loop_enable_o = state_reg.loop2;
	assign first_output_driver_o = state_reg.drv1;
	assign second_output_driver_o = state_reg.drv2;
	assign frame_pulse_output_o = state_reg.frame;
	assign pll_lock_indicator_o = state_reg.lock;
	assign config_fault_o = state_reg.fault;
endmodule : lrcc_line_rate_clock_config

// ### lrcc_host_model.sv
// Host model that sends serial frames to the configuration block.
`timescale 1ns/1ps
module lrcc_host_model
	import lrcc_pkg::*;
(
	// Clock.
	input wire logic clock_i,
	// Serial pins.
	input wire logic sdo_i,
	output logic sclk_o,
	output logic sdi_o,
	output logic cs_n_o,
	// Front-end divider tick.
	output logic div_tick_o
);
	parameter int DIV_RATIO = 193;
	int div_cnt = 0;
	initial begin
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		cs_n_o = 1'b1;
		div_tick_o = 1'b0;
	end
	// Stand-in for the front-end divider; the system clock plays the line clock to keep the run short.
	always @(posedge clock_i) begin
		if (div_cnt == DIV_RATIO - 1) begin
			div_cnt <= 0;
			div_tick_o <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1;
			div_tick_o <= 1'b0;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : tick
	// Read data bit k stands after the falling edge that follows frame bit 3+k and is sampled before the next rise.
	task automatic xfer(input logic rd, input logic [2:0] a, input logic [4:0] d, output logic [4:0] q);
		logic [8:0] f;
		f = {d, a, rd};
		q = 5'h00;
		tick(1);
		cs_n_o = 1'b0;
		for (int i = 0; i < 9; i++) begin
			sdi_o = f[i];
			tick(6);
			if (i > 3) q[i-4] = sdo_i;
			sclk_o = 1'b1;
			tick(6);
			sclk_o = 1'b0;
		end
		tick(6);
		cs_n_o = 1'b1;
		// The data line is released, so it must not keep the last bit.
		sdi_o = ~sdi_o;
		tick(10);
	endtask : xfer
endmodule : lrcc_host_model

// ### lrcc_cfg_sva.sv
// Checker of the configuration outputs of the line rate clock block.
`timescale 1ns/1ps
module lrcc_cfg_sva
	import lrcc_pkg::*;
(
	// Watched ports.
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic forward_master_o,
	input wire logic reverse_slave_o,
	input wire logic [LRCC_DATA_W-1:0] reference_multiple_o,
	input wire logic first_loop_enable_o,
	input wire logic second_loop_enable_o,
	input wire logic first_output_driver_o,
	input wire logic second_output_driver_o,
	input wire logic frame_pulse_output_o,
	input wire logic pll_lock_indicator_o,
	input wire logic config_fault_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	a_modes_exclusive: assert property (!(forward_master_o && reverse_slave_o))
		else $error("both modes active");
	a_slave_multiple: assert property (reverse_slave_o |-> reference_multiple_o == 5'h01 && !config_fault_o)
		else $error("slave mode multiple or fault wrong");
	a_multiple_range: assert property (reference_multiple_o inside {[5'h01:5'h10]})
		else $error("multiple out of range");
	a_driver1_gate: assert property (first_output_driver_o |->
		first_loop_enable_o && (forward_master_o || reverse_slave_o))
		else $error("first driver without loop");
	a_driver2_gate: assert property (second_output_driver_o |-> second_loop_enable_o)
		else $error("second driver without loop");
	a_outputs_need_mode: assert property ((pll_lock_indicator_o || frame_pulse_output_o) |->
		forward_master_o || reverse_slave_o)
		else $error("output enabled without mode");
	a_fault_mode: assert property (!config_fault_o |-> forward_master_o || reverse_slave_o)
		else $error("no fault without valid mode");
	a_write_after_frame: assert property ($rose(first_loop_enable_o) |-> cs_n_i && $past(cs_n_i, 3))
		else $error("register changed inside frame");
	a_reset_values: assert property (disable iff (1'b0) !reset_n_i |=>
		config_fault_o && reference_multiple_o == 5'h01 && !first_loop_enable_o)
		else $error("reset values wrong");
endmodule : lrcc_cfg_sva
bind lrcc_line_rate_clock_config lrcc_cfg_sva i_lrcc_cfg_sva (.clock_i(clock_i), .reset_n_i(reset_n_i),
	.cs_n_i(cs_n_i), .forward_master_o(forward_master_o), .reverse_slave_o(reverse_slave_o),
	.reference_multiple_o(reference_multiple_o), .first_loop_enable_o(first_loop_enable_o),
	.second_loop_enable_o(second_loop_enable_o), .first_output_driver_o(first_output_driver_o),
	.second_output_driver_o(second_output_driver_o), .frame_pulse_output_o(frame_pulse_output_o),
	.pll_lock_indicator_o(pll_lock_indicator_o), .config_fault_o(config_fault_o));

// ### lrcc_line_rate_clock_config_tb.sv
// Self-checking testbench of the line rate clock configuration block.
`timescale 1ns/1ps
module lrcc_line_rate_clock_config_tb;
	import lrcc_pkg::*;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic sel = 1'b0;
	logic lk1 = 1'b0;
	logic lk2 = 1'b0;
	logic sclk, sdi, cs_n, sdo, fm, rs, le1, le2, d1, d2, fp, li, cf, dt;
	logic [4:0] mult;
	logic [4:0] q;
	logic [8:0] st;
	int fail_count = 0;
	int n_compared = 0;
	assign st = {fm, rs, le1, le2, d1, d2, fp, li, cf};
	always #4 clock_i = ~clock_i;
	lrcc_line_rate_clock_config i_lrcc_line_rate_clock_config (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.sclk_i(sclk), .sdi_i(sdi), .cs_n_i(cs_n), .sdo_o(sdo), .line_rate_select_i(sel),
		.first_loop_locked_i(lk1), .second_loop_locked_i(lk2), .forward_master_o(fm), .reverse_slave_o(rs),
		.reference_multiple_o(mult), .first_loop_enable_o(le1), .second_loop_enable_o(le2),
		.first_output_driver_o(d1), .second_output_driver_o(d2), .frame_pulse_output_o(fp),
		.pll_lock_indicator_o(li), .config_fault_o(cf));
	lrcc_host_model i_lrcc_host_model (.clock_i(clock_i), .sdo_i(sdo), .sclk_o(sclk), .sdi_o(sdi), .cs_n_o(cs_n),
		.div_tick_o(dt));
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [2:0] a, input logic [4:0] d);
		i_lrcc_host_model.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [4:0] exp);
		i_lrcc_host_model.xfer(1'b1, a, 5'h00, q);
		check("readback", q, exp);
	endtask : rd
	task automatic settle();
		repeat (6) @(posedge clock_i);
		#1;
	endtask : settle
	task automatic t_reset();
		check("status", st, 9'h001);
		check("multiple", mult, 5'h01);
		rd(LRCC_MODE_FIRST_OFS, 5'h00);
	endtask : t_reset
	task automatic t_forward();
		sel = 1'b1;
		wr(LRCC_MODE_FIRST_OFS, 5'h11);
		wr(LRCC_MULT_SECOND_OFS, 5'h07);
		wr(LRCC_FIRST_DIV_OFS, LRCC_DIV_REQUIRED);
		wr(LRCC_SECOND_DIV_OFS, LRCC_DIV_REQUIRED);
		wr(LRCC_OUT_EN_OFS, 5'h1F);
		lk1 = 1'b1;
		lk2 = 1'b1;
		settle();
		check("status", st, 9'h17E);
		check("multiple", mult, 5'h04);
		lk1 = 1'b0;
		settle();
		check("status", st, 9'h17C);
		wr(LRCC_OUT_EN_OFS, 5'h12);
		check("status", st, 9'h166);
		wr(LRCC_FIRST_DIV_OFS, 5'h1E);
		check("status", st, 9'h167);
	endtask : t_forward
	task automatic t_reverse();
		sel = 1'b0;
		wr(LRCC_MULT_SECOND_OFS, 5'h01);
		check("status", st, 9'h0E6);
		check("multiple", mult, 5'h01);
		wr(LRCC_MODE_FIRST_OFS, 5'h01);
		check("status", st, 9'h061);
		rd(LRCC_MULT_SECOND_OFS, 5'h01);
		rd(LRCC_OUT_EN_OFS, 5'h12);
		wr(3'h5, 5'h1F);
		rd(3'h5, 5'h00);
	endtask : t_reverse
	task automatic t_divider();
		int n;
		n = 0;
		repeat (386) begin
			@(posedge clock_i);
			#1;
			if (dt) n++;
		end
		check("divider ticks", 9'(n), 9'h002);
	endtask : t_divider
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20) @(posedge clock_i);
		#1;
		reset_n_i = 1'b1;
		t_reset();
		t_forward();
		t_reverse();
		// A second reset in mid-run must clear registers that now hold nonzero values.
		reset_n_i = 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		reset_n_i = 1'b1;
		t_reset();
		t_divider();
		wrap_up();
	end
	// Fifteen frames and the divider check need about 2300 cycles; the limit leaves a wide margin.
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
endmodule : lrcc_line_rate_clock_config_tb
